// File: src/pss_pin_select.sv
// pin signal select, input readback and time stamp trigger with apb registers
// Summary of operation
// - codes 0x37 to 0x3B drive the pin with led pulse of slots H to L.
// - code 0x3F drives the pin with the led pulse of any slot.
// - codes 0x40 to 0x4B drive modulation pulse of slots A to L.
// - code 0x4F drives modulation pulse of any slot.
// - codes 0x50 to 0x5B mark output data cycle of slots A to L.
// - code 0x5F marks output data cycle of any slot.
// - pin zero selector sits at bits 6 to 0, resets zero, bit 7 reads zero.
// - input field returns levels of input-enabled pins, bit 0 is pin zero.
// - pattern code 0x10 returns pin to idle level after each slot and in sleep.
// - edge invert bit 7 picks rising edge when clear, falling when set.
// - keep-armed bit 6 stops a capture from disarming the stamp.
// - stamp pin select bits 5 to 4, reset zero, selects pin zero.
// - stamp pin select value one selects pin one.
// - pattern code 0x10 outputs per-slot pattern bits or idle level.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pss_consts.svh"
module pss_pin_select #(
	parameter int STAMP_W = 16
) (
	input wire logic                   clk,
	input wire logic                   rst_n,
	input wire logic [11:0]            paddr,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [31:0]            pwdata,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	input wire pss_pkg::pss_slots_type slotActive,
	input wire pss_pkg::pss_slots_type ledPulse,
	input wire pss_pkg::pss_slots_type modPulse,
	input wire pss_pkg::pss_slots_type dataCycle,
	input wire logic                   sleepState,
	input wire pss_pkg::pss_slots_type slotPattern0,
	input wire pss_pkg::pss_slots_type slotPattern1,
	input wire pss_pkg::pss_pins_type  pinIn,
	output logic [1:0]                 pinOut,
	output logic [1:0]                 pinOe_n,
	output logic                       stampCapture,
	output logic                       stampArmed
);
	// --------------------------------------------------------------
	// apb decode
	// --------------------------------------------------------------
	// unaligned addresses never hit, so they fall to the error answer
	function automatic logic regHit(input logic [11:0] addr, input logic [9:0] idx);
		regHit = (addr[1:0] == 2'h0) && (addr[11:2] == idx);
	endfunction

	logic setupPhase;
	logic wrEn;

	// zero wait states: every access phase completes at once
	assign setupPhase = psel && !penable;
	assign wrEn = psel && penable && pwrite;
	assign pready = psel && penable;

	// --------------------------------------------------------------
	// configuration registers
	// --------------------------------------------------------------
	pss_pkg::pss_sel_type sel0_reg, sel0_next;
	pss_pkg::pss_sel_type sel1_reg, sel1_next;
	logic                 idleLevel_reg, idleLevel_next;
	logic                 stampInv_reg, stampInv_next;
	logic                 keepArmed_reg, keepArmed_next;
	logic [1:0]           stampPin_reg, stampPin_next;
	logic [1:0]           inEnable_reg, inEnable_next;
	logic [1:0]           outEnable_reg, outEnable_next;

	// writes take effect only at the completing access edge
	always_comb begin
		sel0_next = sel0_reg;
		sel1_next = sel1_reg;
		idleLevel_next = idleLevel_reg;
		stampInv_next = stampInv_reg;
		keepArmed_next = keepArmed_reg;
		stampPin_next = stampPin_reg;
		inEnable_next = inEnable_reg;
		outEnable_next = outEnable_reg;
		if (wrEn && regHit(paddr, `PSS_IDX_OUTSEL)) begin
			sel0_next = pwdata[`PSS_SEL0_MSB:`PSS_SEL0_LSB];
			sel1_next = pwdata[`PSS_SEL1_MSB:`PSS_SEL1_LSB];
		end
		if (wrEn && regHit(paddr, `PSS_IDX_EXT)) begin
			idleLevel_next = pwdata[`PSS_EXT_IDLE_BIT];
			stampInv_next = pwdata[`PSS_EXT_INV_BIT];
			keepArmed_next = pwdata[`PSS_EXT_KEEP_BIT];
			stampPin_next = pwdata[`PSS_EXT_PIN_MSB:`PSS_EXT_PIN_LSB];
		end
		if (wrEn && regHit(paddr, `PSS_IDX_PINDIR)) begin
			inEnable_next = pwdata[`PSS_DIR_IN_MSB:`PSS_DIR_IN_LSB];
			outEnable_next = pwdata[`PSS_DIR_OUT_MSB:`PSS_DIR_OUT_LSB];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sel0_reg <= `PSS_RST_SEL;
			sel1_reg <= `PSS_RST_SEL;
			idleLevel_reg <= `PSS_RST_BIT;
			stampInv_reg <= `PSS_RST_BIT;
			keepArmed_reg <= `PSS_RST_BIT;
			stampPin_reg <= `PSS_RST_PINSEL;
			inEnable_reg <= `PSS_RST_PAIR;
			outEnable_reg <= `PSS_RST_PAIR;
		end else begin
			sel0_reg <= sel0_next;
			sel1_reg <= sel1_next;
			idleLevel_reg <= idleLevel_next;
			stampInv_reg <= stampInv_next;
			keepArmed_reg <= keepArmed_next;
			stampPin_reg <= stampPin_next;
			inEnable_reg <= inEnable_next;
			outEnable_reg <= outEnable_next;
		end
	end

	// --------------------------------------------------------------
	// pin selectors
	// --------------------------------------------------------------
	pss_event_if evt ();
	logic [1:0] muxLevel;

	assign evt.slotActive = slotActive;
	assign evt.ledPulse = ledPulse;
	assign evt.modPulse = modPulse;
	assign evt.dataCycle = dataCycle;
	assign evt.sleepState = sleepState;
	assign evt.idleLevel = idleLevel_reg;

	pss_pin_mux u_mux0 (
		.evt     (evt),
		.sel     (sel0_reg),
		.pattern (slotPattern0),
		.level   (muxLevel[0])
	);

	pss_pin_mux u_mux1 (
		.evt     (evt),
		.sel     (sel1_reg),
		.pattern (slotPattern1),
		.level   (muxLevel[1])
	);

	// --------------------------------------------------------------
	// pin synchronisers and output flops
	// --------------------------------------------------------------
	logic [1:0] pinMeta_reg, pinMeta_next;
	logic [1:0] pinSync_reg, pinSync_next;
	logic [1:0] pinPrev_reg, pinPrev_next;
	logic [1:0] inLevel_reg, inLevel_next;
	logic [1:0] pinOut_reg, pinOut_next;

	// pins are asynchronous: two flops before edge detect or readback
	always_comb begin
		pinMeta_next = pinIn;
		pinSync_next = pinMeta_reg;
		pinPrev_next = pinSync_reg;
		inLevel_next = pinSync_reg & inEnable_reg;
		pinOut_next = muxLevel;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pinMeta_reg <= `PSS_RST_PAIR;
			pinSync_reg <= `PSS_RST_PAIR;
			pinPrev_reg <= `PSS_RST_PAIR;
			inLevel_reg <= `PSS_RST_PAIR;
			pinOut_reg <= `PSS_RST_PAIR;
		end else begin
			pinMeta_reg <= pinMeta_next;
			pinSync_reg <= pinSync_next;
			pinPrev_reg <= pinPrev_next;
			inLevel_reg <= inLevel_next;
			pinOut_reg <= pinOut_next;
		end
	end

	assign pinOut = pinOut_reg;
	assign pinOe_n = ~outEnable_reg;

	// --------------------------------------------------------------
	// time stamp trigger
	// --------------------------------------------------------------
	logic               trigNow;
	logic               trigPrev;
	logic               trigEdge;
	logic               arm_reg, arm_next;
	logic               capture_reg, capture_next;
	logic [STAMP_W-1:0] stampCount_reg, stampCount_next;
	logic [STAMP_W-1:0] stampValue_reg, stampValue_next;
	logic               armWrite;

	// software access to the arm register
	assign armWrite = wrEn && regHit(paddr, `PSS_IDX_ARM);

	// selects 2 and 3 name pins this block lacks, so they never fire
	always_comb begin
		trigNow = 1'b0;
		trigPrev = 1'b0;
		case (stampPin_reg)
			`PSS_PIN_ZERO: begin
				trigNow = pinSync_reg[0];
				trigPrev = pinPrev_reg[0];
			end
			`PSS_PIN_ONE: begin
				trigNow = pinSync_reg[1];
				trigPrev = pinPrev_reg[1];
			end
			default: begin
				trigNow = 1'b0;
				trigPrev = 1'b0;
			end
		endcase
		trigEdge = stampInv_reg ? (trigPrev && !trigNow) : (!trigPrev && trigNow);
	end

	// a software arm in the capture cycle wins over the auto clear
	always_comb begin
		capture_next = arm_reg && trigEdge;
		stampCount_next = stampCount_reg + STAMP_W'(1);
		stampValue_next = capture_next ? stampCount_reg : stampValue_reg;
		arm_next = arm_reg;
		if (capture_next && !keepArmed_reg) begin
			arm_next = 1'b0;
		end
		// written value always wins: 1 arms, 0 disarms
		if (armWrite) begin
			arm_next = pwdata[`PSS_ARM_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			arm_reg <= `PSS_RST_BIT;
			capture_reg <= `PSS_RST_BIT;
			stampCount_reg <= '0;
			stampValue_reg <= '0;
		end else begin
			arm_reg <= arm_next;
			capture_reg <= capture_next;
			stampCount_reg <= stampCount_next;
			stampValue_reg <= stampValue_next;
		end
	end

	assign stampCapture = capture_reg;
	assign stampArmed = arm_reg;

	// --------------------------------------------------------------
	// read data and error answer
	// --------------------------------------------------------------
	logic [31:0] prdata_reg, prdata_next;
	logic        pslverr_reg, pslverr_next;

	// loaded at the setup edge so the access phase shows flopped data
	always_comb begin
		prdata_next = prdata_reg;
		pslverr_next = pslverr_reg;
		if (setupPhase) begin
			prdata_next = `PSS_RST_WORD;
			pslverr_next = 1'b0;
			if (regHit(paddr, `PSS_IDX_OUTSEL)) begin
				prdata_next = 32'({1'b0, sel1_reg, 1'b0, sel0_reg});
			end else if (regHit(paddr, `PSS_IDX_INPUT)) begin
				prdata_next = 32'(inLevel_reg);
			end else if (regHit(paddr, `PSS_IDX_EXT)) begin
				prdata_next = 32'({idleLevel_reg, stampInv_reg, keepArmed_reg,
					stampPin_reg, 4'h0});
			end else if (regHit(paddr, `PSS_IDX_PINDIR)) begin
				prdata_next = 32'({outEnable_reg, 2'h0, inEnable_reg});
			end else if (regHit(paddr, `PSS_IDX_ARM)) begin
				prdata_next = 32'(arm_reg);
			end else if (regHit(paddr, `PSS_IDX_STAMP)) begin
				prdata_next = 32'(stampValue_reg);
			end else begin
				pslverr_next = 1'b1;
			end
			if (pwrite) begin
				prdata_next = `PSS_RST_WORD;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prdata_reg <= `PSS_RST_WORD;
			pslverr_reg <= 1'b0;
		end else begin
			prdata_reg <= prdata_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg;

	// --------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------
	logic anyLed;
	logic anyMod;
	logic anyData;
	logic rise0;
	logic fall0;
	logic rise1;

	assign anyLed = |ledPulse;
	assign anyMod = |modPulse;
	assign anyData = |dataCycle;
	assign rise0 = !pinPrev_reg[0] && pinSync_reg[0];
	assign fall0 = pinPrev_reg[0] && !pinSync_reg[0];
	assign rise1 = !pinPrev_reg[1] && pinSync_reg[1];

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	property p_led_h;
		sel0_reg == `PSS_SEL_LED_H |=> pinOut_reg[0] == $past(ledPulse[`PSS_SLOT_H]);
	endproperty
	a_led_h: assert property (p_led_h) else $error("pin zero misses slot H led");

	property p_led_any;
		sel1_reg == `PSS_SEL_LED_ANY |=> pinOut_reg[1] == $past(anyLed);
	endproperty
	a_led_any: assert property (p_led_any) else $error("pin one misses any led");

	property p_mod_l;
		sel0_reg == `PSS_SEL_MOD_L |=> pinOut_reg[0] == $past(modPulse[`PSS_SLOT_L]);
	endproperty
	a_mod_l: assert property (p_mod_l) else $error("pin zero misses slot L mod");

	property p_mod_any;
		sel1_reg == `PSS_SEL_MOD_ANY |=> pinOut_reg[1] == $past(anyMod);
	endproperty
	a_mod_any: assert property (p_mod_any) else $error("pin one misses any mod");

	property p_data_a;
		sel0_reg == `PSS_SEL_DATA_A |=> pinOut_reg[0] == $past(dataCycle[`PSS_SLOT_A]);
	endproperty
	a_data_a: assert property (p_data_a) else $error("pin zero misses slot A data");

	property p_data_any;
		sel1_reg == `PSS_SEL_DATA_ANY |=> pinOut_reg[1] == $past(anyData);
	endproperty
	a_data_any: assert property (p_data_any) else $error("pin one misses any data");

	property p_sel_write;
		wrEn && regHit(paddr, `PSS_IDX_OUTSEL) |=>
			sel0_reg == $past(pwdata[`PSS_SEL0_MSB:`PSS_SEL0_LSB]);
	endproperty
	a_sel_write: assert property (p_sel_write) else $error("pin zero selector write");

	property p_sel_rsvd;
		setupPhase && regHit(paddr, `PSS_IDX_OUTSEL) |=> !prdata_reg[7] && !prdata_reg[15];
	endproperty
	a_sel_rsvd: assert property (p_sel_rsvd) else $error("selector reserved bit set");

	property p_input_read;
		setupPhase && !pwrite && regHit(paddr, `PSS_IDX_INPUT) |=>
			prdata_reg[31:2] == 30'h0000_0000 && prdata_reg[1:0] == $past(inLevel_reg);
	endproperty
	a_input_read: assert property (p_input_read) else $error("input readback wrong");

	property p_idle;
		sel0_reg == `PSS_SEL_PATTERN && (sleepState || slotActive == 12'h000) |=>
			pinOut_reg[0] == $past(idleLevel_reg);
	endproperty
	a_idle: assert property (p_idle) else $error("pattern pin not at idle level");

	property p_fall;
		arm_reg && stampPin_reg == `PSS_PIN_ZERO && stampInv_reg && fall0 |=> capture_reg;
	endproperty
	a_fall: assert property (p_fall) else $error("falling edge not captured");

	property p_keep;
		capture_reg && $past(keepArmed_reg) && !$past(armWrite) |-> arm_reg;
	endproperty
	a_keep: assert property (p_keep) else $error("keep armed lost the arm");

	property p_rise0;
		arm_reg && stampPin_reg == `PSS_PIN_ZERO && !stampInv_reg && rise0 |=> capture_reg;
	endproperty
	a_rise0: assert property (p_rise0) else $error("pin zero rise not captured");

	property p_rise1;
		arm_reg && stampPin_reg == `PSS_PIN_ONE && !stampInv_reg && rise1 |=> capture_reg;
	endproperty
	a_rise1: assert property (p_rise1) else $error("pin one rise not captured");

	property p_pattern;
		sel0_reg == `PSS_SEL_PATTERN && !sleepState && slotActive == `PSS_ONLY_A |=>
			pinOut_reg[0] == $past(slotPattern0[`PSS_SLOT_A]);
	endproperty
	a_pattern: assert property (p_pattern) else $error("slot pattern bit not driven");

	property p_ext_rsvd;
		setupPhase && regHit(paddr, `PSS_IDX_EXT) |=>
			prdata_reg[31:9] == 23'h00_0000 && prdata_reg[3:0] == 4'h0;
	endproperty
	a_ext_rsvd: assert property (p_ext_rsvd) else $error("reserved bits not zero");

	c_capture: cover property (capture_reg && keepArmed_reg);
	c_led_any: cover property (sel0_reg == `PSS_SEL_LED_ANY && anyLed);
	c_slverr: cover property (pready && pslverr);
endmodule
`default_nettype wire

// File: inc/pss_consts.svh
// register map, field layout and selector codes of the pin signal select block
`ifndef PSS_CONSTS_SVH
`define PSS_CONSTS_SVH
// register indices, byte address is four times the index
`define PSS_IDX_OUTSEL 10'h023
`define PSS_IDX_INPUT 10'h025
`define PSS_IDX_EXT 10'h026
`define PSS_IDX_PINDIR 10'h027
`define PSS_IDX_ARM 10'h028
`define PSS_IDX_STAMP 10'h029
// output select fields
`define PSS_SEL0_MSB 6
`define PSS_SEL0_LSB 0
`define PSS_SEL1_MSB 14
`define PSS_SEL1_LSB 8
// extension register fields
`define PSS_EXT_IDLE_BIT 8
`define PSS_EXT_INV_BIT 7
`define PSS_EXT_KEEP_BIT 6
`define PSS_EXT_PIN_MSB 5
`define PSS_EXT_PIN_LSB 4
// direction register fields
`define PSS_DIR_IN_MSB 1
`define PSS_DIR_IN_LSB 0
`define PSS_DIR_OUT_MSB 5
`define PSS_DIR_OUT_LSB 4
`define PSS_ARM_BIT 0
// reset values
`define PSS_RST_SEL 7'h00
`define PSS_RST_PINSEL 2'h0
`define PSS_RST_PAIR 2'h0
`define PSS_RST_BIT 1'b0
`define PSS_RST_WORD 32'h0000_0000
// selector codes and code groups
`define PSS_SEL_LOW 7'h00
`define PSS_SEL_HIGH 7'h01
`define PSS_SEL_PATTERN 7'h10
`define PSS_SEL_SLEEP 7'h11
`define PSS_SEL_LED_H 7'h37
`define PSS_SEL_LED_ANY 7'h3f
`define PSS_SEL_MOD_L 7'h4b
`define PSS_SEL_MOD_ANY 7'h4f
`define PSS_SEL_DATA_A 7'h50
`define PSS_SEL_DATA_ANY 7'h5f
`define PSS_GRP_ACTIVE 3'h2
`define PSS_GRP_LED 3'h3
`define PSS_GRP_MOD 3'h4
`define PSS_GRP_DATA 3'h5
`define PSS_SUB_ANY 4'hf
`define PSS_SLOTS 12
`define PSS_SLOT_A 0
`define PSS_SLOT_H 7
`define PSS_SLOT_L 11
`define PSS_ONLY_A 12'h001
// stamp pin select codes
`define PSS_PIN_ZERO 2'h0
`define PSS_PIN_ONE 2'h1
`endif

// File: inc/pss_pkg.sv
// shared types of the pin signal select block
`default_nettype none
package pss_pkg;
	typedef logic [6:0] pss_sel_type;
	typedef logic [11:0] pss_slots_type;
	typedef logic [1:0] pss_pins_type;
endpackage
`default_nettype wire

// File: inc/pss_event_if.sv
// timing events carried from the top to each pin selector
`timescale 1ns/1ps
`default_nettype none
interface pss_event_if;
	pss_pkg::pss_slots_type slotActive;
	pss_pkg::pss_slots_type ledPulse;
	pss_pkg::pss_slots_type modPulse;
	pss_pkg::pss_slots_type dataCycle;
	logic                   sleepState;
	logic                   idleLevel;
	modport src (output slotActive, ledPulse, modPulse, dataCycle, sleepState, idleLevel);
	modport sink (input slotActive, ledPulse, modPulse, dataCycle, sleepState, idleLevel);
endinterface
`default_nettype wire

// File: src/pss_pin_mux.sv
// one pin's output selector: picks a timing event by selector code
`timescale 1ns/1ps
`default_nettype none
`include "pss_consts.svh"
module pss_pin_mux (
	pss_event_if.sink              evt,
	input wire pss_pkg::pss_sel_type   sel,
	input wire pss_pkg::pss_slots_type pattern,
	output logic                   level
);
	// --------------------------------------------------------------
	// slot decode helpers
	// --------------------------------------------------------------
	// codes past slot L inside a group are undefined and give low
	function automatic logic slotPick(input pss_pkg::pss_slots_type vec,
		input logic [3:0] sub);
		slotPick = (sub < 4'(`PSS_SLOTS)) ? vec[sub] : 1'b0;
	endfunction

	// sub-code of all ones merges every slot
	function automatic logic groupPick(input pss_pkg::pss_slots_type vec,
		input logic [3:0] sub);
		groupPick = (sub == `PSS_SUB_ANY) ? (|vec) : slotPick(vec, sub);
	endfunction

	logic patternLevel;

	// --------------------------------------------------------------
	// selector
	// --------------------------------------------------------------
	// pattern falls back to idle level between slots and in sleep
	always_comb begin
		patternLevel = evt.idleLevel;
		if (!evt.sleepState && (|evt.slotActive)) begin
			patternLevel = |(evt.slotActive & pattern);
		end
		case (sel)
			`PSS_SEL_LOW: level = 1'b0;
			`PSS_SEL_HIGH: level = 1'b1;
			`PSS_SEL_PATTERN: level = patternLevel;
			`PSS_SEL_SLEEP: level = evt.sleepState;
			default: begin
				case (sel[6:4])
					`PSS_GRP_ACTIVE: level = slotPick(evt.slotActive, sel[3:0]);
					`PSS_GRP_LED: level = groupPick(evt.ledPulse, sel[3:0]);
					`PSS_GRP_MOD: level = groupPick(evt.modPulse, sel[3:0]);
					`PSS_GRP_DATA: level = groupPick(evt.dataCycle, sel[3:0]);
					default: level = 1'b0;
				endcase
			end
		endcase
	end
endmodule
`default_nettype wire

// File: verification/pss_pin_partner.sv
// far-side model: external devices that drive and watch the two pins
`timescale 1ns/1ps
`default_nettype none
module pss_pin_partner (
	input wire logic       clk,
	input wire logic [1:0] pinOut,
	input wire logic [1:0] pinOe_n,
	input wire logic [1:0] drvLevel,
	input wire logic [1:0] drvEn,
	output logic [1:0]     pinIn
);
	logic [1:0] floatLevel_reg = 2'h0;
	// no pull on the wire, so an undriven pin wanders instead of holding
	always @(posedge clk) begin
		floatLevel_reg <= ~floatLevel_reg;
	end
	// device drive wins, then the external device, else the wandering level
	always_comb begin
		for (int n = 0; n < 2; n++) begin
			pinIn[n] = !pinOe_n[n] ? pinOut[n] : (drvEn[n] ? drvLevel[n] : floatLevel_reg[n]);
		end
	end
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// self-checking testbench of the pin signal select block
`timescale 1ns/1ps
`default_nettype none
`include "pss_consts.svh"
module tb_top;
	logic                   clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic                   sleepState, stampCapture, stampArmed;
	logic [11:0]            paddr;
	logic [31:0]            pwdata, prdata, rdv;
	pss_pkg::pss_slots_type slotActive, ledPulse, modPulse, dataCycle, pat0, pat1;
	pss_pkg::pss_pins_type  pinIn;
	logic [1:0]             pinOut, pinOe_n, drvLevel, drvEn;
	int                     n_fail = 0;
	int                     checks_done = 0;

	pss_pin_select uut (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .slotActive(slotActive),
		.ledPulse(ledPulse), .modPulse(modPulse), .dataCycle(dataCycle),
		.sleepState(sleepState), .slotPattern0(pat0), .slotPattern1(pat1),
		.pinIn(pinIn), .pinOut(pinOut), .pinOe_n(pinOe_n),
		.stampCapture(stampCapture), .stampArmed(stampArmed));
	pss_pin_partner far (.clk(clk), .pinOut(pinOut), .pinOe_n(pinOe_n),
		.drvLevel(drvLevel), .drvEn(drvEn), .pinIn(pinIn));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// apb transfer held until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'h0};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge clk);
		end
		if (n >= 20) n_fail++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
		logic [31:0] r;
		logic        e;
		apb(1'b1, idx, wd, r, e);
	endtask
	task automatic rdChk(input logic [9:0] idx, input logic [31:0] exp);
		logic e;
		apb(1'b0, idx, 32'h0000_0000, rdv, e);
		chk(rdv, exp);
		chk(e, 1'h0);
	endtask
	// one event kind on, all others off
	task automatic setEv(input int kind, input logic [11:0] v);
		@(posedge clk);
		ledPulse <= (kind == 0) ? v : 12'h000;
		modPulse <= (kind == 1) ? v : 12'h000;
		dataCycle <= (kind == 2) ? v : 12'h000;
		@(posedge clk);
		@(posedge clk);
	endtask
	// selector code on pin p: own slot gives 1, the other slots give 0 (an any code gets no slots instead)
	task automatic chkCode(input int p, input logic [6:0] code, input int kind,
		input int slot, input bit anyc);
		wr(`PSS_IDX_OUTSEL, 32'(code) << (8 * p));
		setEv(kind, 12'h001 << slot);
		chk(pinOut[p], 1'h1);
		setEv(kind, anyc ? 12'h000 : ~(12'h001 << slot));
		chk(pinOut[p], 1'h0);
	endtask
	task automatic patStep(input logic [11:0] act, input logic slp, input logic idle,
		input logic [1:0] exp);
		wr(`PSS_IDX_EXT, 32'(idle) << 8);
		slotActive <= act;
		sleepState <= slp;
		@(posedge clk);
		@(posedge clk);
		chk(pinOut, exp);
	endtask
	// disarmed move to the from level first, then arm and make the edge under test
	task automatic stampTry(input logic [31:0] ext, input logic [1:0] from,
		input logic [1:0] to, input int expCap, input logic expArm);
		int cap;
		cap = 0;
		wr(`PSS_IDX_ARM, 32'h0000_0000);
		drvLevel <= from;
		repeat (5) @(posedge clk);
		chk(stampArmed, 1'h0);
		wr(`PSS_IDX_EXT, ext);
		wr(`PSS_IDX_ARM, 32'h0000_0001);
		drvLevel <= to;
		repeat (8) begin
			@(posedge clk);
			if (stampCapture === 1'b1) cap++;
		end
		chk(cap, expCap);
		chk(stampArmed, expArm);
	endtask

	// ----------------------------------------
	// clock, watchdog and test sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// the whole sequence needs well under 5000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		finish_test();
	end
	initial begin
		logic e;
		{rst_n, psel, penable, pwrite, sleepState} = 5'h00;
		{paddr, pwdata} = 44'h000_0000_0000;
		{slotActive, ledPulse, modPulse, dataCycle} = 48'h0000_0000_0000;
		pat0 = 12'h004;
		pat1 = 12'h008;
		drvLevel = 2'h0;
		drvEn = 2'h0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		drvEn <= 2'h3;
		rdChk(`PSS_IDX_OUTSEL, 32'h0000_0000);
		rdChk(`PSS_IDX_EXT, 32'h0000_0000);
		rdChk(`PSS_IDX_INPUT, 32'h0000_0000);
		apb(1'b0, 10'h3ff, 32'h0000_0000, rdv, e);
		chk(e, 1'h1);
		wr(`PSS_IDX_OUTSEL, 32'hffff_ffff);
		rdChk(`PSS_IDX_OUTSEL, 32'h0000_7f7f);
		wr(`PSS_IDX_EXT, 32'hffff_ffff);
		rdChk(`PSS_IDX_EXT, 32'h0000_01f0);
		$display("test registers done");
		wr(`PSS_IDX_PINDIR, 32'h0000_0030);
		@(posedge clk);
		chk(pinOe_n, 2'h0);
		for (int i = 0; i < 5; i++) chkCode(i % 2, 7'h37 + 7'(i), 0, 7 + i, 1'b0);
		chkCode(0, 7'h3f, 0, 2, 1'b1);
		for (int i = 0; i < 12; i++) chkCode(i % 2, 7'h40 + 7'(i), 1, i, 1'b0);
		chkCode(1, 7'h4f, 1, 9, 1'b1);
		for (int i = 0; i < 12; i++) chkCode((i + 1) % 2, 7'h50 + 7'(i), 2, i, 1'b0);
		chkCode(0, 7'h5f, 2, 11, 1'b1);
		$display("test selector codes done");
		wr(`PSS_IDX_OUTSEL, 32'h0000_1010);
		patStep(12'h004, 1'b0, 1'b0, 2'h1);
		patStep(12'h008, 1'b0, 1'b0, 2'h2);
		patStep(12'h000, 1'b0, 1'b1, 2'h3);
		patStep(12'h000, 1'b0, 1'b0, 2'h0);
		patStep(12'h004, 1'b1, 1'b1, 2'h3);
		patStep(12'h00c, 1'b1, 1'b0, 2'h0);
		$display("test slot pattern done");
		wr(`PSS_IDX_PINDIR, 32'h0000_0001);
		drvLevel <= 2'h3;
		repeat (6) @(posedge clk);
		rdChk(`PSS_IDX_INPUT, 32'h0000_0001);
		wr(`PSS_IDX_PINDIR, 32'h0000_0003);
		wr(`PSS_IDX_INPUT, 32'h0000_ffff);
		drvLevel <= 2'h2;
		repeat (6) @(posedge clk);
		rdChk(`PSS_IDX_INPUT, 32'h0000_0002);
		$display("test input readback done");
		stampTry(32'h0000_0000, 2'h0, 2'h1, 1, 1'b0);
		stampTry(32'h0000_0080, 2'h1, 2'h0, 1, 1'b0);
		stampTry(32'h0000_0080, 2'h0, 2'h1, 0, 1'b1);
		stampTry(32'h0000_0040, 2'h0, 2'h1, 1, 1'b1);
		stampTry(32'h0000_0010, 2'h0, 2'h1, 0, 1'b1);
		stampTry(32'h0000_0010, 2'h0, 2'h2, 1, 1'b0);
		$display("test time stamp done");
		finish_test();
	end
endmodule
`default_nettype wire
